// file: logic/mdp_pkg.sv
package mdp_pkg;
	// Operating mode as strapped on the two mode pins {b, a}.
	typedef enum logic [1:0] {
		MDP_BOOT = 2'h0,
		MDP_TEST = 2'h1,
		MDP_SINGLE = 2'h2,
		MDP_EXPANDED = 2'h3
	} mdp_mode_t;

	// External bus sequencer, Gray coded along idle, address, data.
	typedef enum logic [1:0] {
		MDP_BUS_IDLE = 2'h0,
		MDP_BUS_ADDR = 2'h1,
		MDP_BUS_DATA = 2'h3
	} mdp_bus_t;

	// Oscillator cycles per bus timing period and phase markers.
	localparam int MDP_E_DIV = 4;
	localparam logic [1:0] MDP_PH_STROBE = 2'h0;
	localparam logic [1:0] MDP_PH_DATA = 2'h2;
	localparam logic [1:0] MDP_PH_LAST = 2'h3;

	// Values after reset.
	localparam logic [7:0] MDP_LATCH_RST = 8'h00;
	localparam logic [7:0] MDP_DIR_RST = 8'h00;
	localparam logic [7:0] MDP_PA_FIXED_OUT = 8'h70;
	localparam logic [15:0] MDP_ADDR_RST = 16'h0000;
	localparam logic [1:0] MDP_CAP_RST = 2'h0;

	// Field positions.
	localparam int MDP_PA_OC_HI = 7;
	localparam int MDP_PA_OC_LO = 3;
	localparam int MDP_PD_RXD = 0;
	localparam int MDP_PD_TXD = 1;
	localparam int MDP_PD_SPI_LO = 2;
	localparam int MDP_PD_SPI_HI = 5;
	localparam int MDP_PD_STROBE = 6;
	localparam int MDP_PD_RW = 7;
endpackage

// file: logic/mdp_sync.sv
`timescale 1ns/100ps
module mdp_sync #(
	parameter int W = 8
) (
	// Clock.
	input wire logic clk,
	// Asynchronous levels in, resynchronised levels out.
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_reg;

	// Pin levels carry no reset; the first stage feeds only the second.
	always_ff @(posedge clk) begin
		meta_reg <= d;
		q <= meta_reg;
	end
endmodule

// file: logic/mdp_eclk.sv
`timescale 1ns/100ps
module mdp_eclk (
	// Clock and reset.
	input wire logic clk,
	input wire logic nrst,
	// Phase of the bus timing period, 0 and 1 low, 2 and 3 high.
	output logic [1:0] phase
);
	import mdp_pkg::*;

	logic [1:0] phase_next;

	assign phase_next = (phase == 2'(MDP_E_DIV - 1)) ? 2'h0 : phase + 2'h1;

	always_ff @(posedge clk) begin
		if (!nrst) begin
			phase <= MDP_PH_STROBE;
		end else begin
			phase <= phase_next;
		end
	end
endmodule

// file: logic/mdp_port_pins.sv
`timescale 1ns/100ps
// How it works
// - Port D bit 7: I/O or read/write line.
// - Read/write line high during bus reads.
// - Ports B, C, D6-7 free only single/boot.
// - Expanded: port B carries address 15:8.
// - Port C: low address, then data.
// - Port D shared with serial units.
// - Reads return pin or driver input.
// - Port A latch drives outputs, not compares.
// - Port A reset: 6:4 low outputs.
// - Bits 7, 3 direction from accumulator control.
// - Latches B, C, D drive only outputs.
// - Port B reset direction by mode.
// - Port C reset function by mode.
// - Open-drain: ones float, zeros drive low.
// - Open-drain only in single-chip mode.
// - Bus modes: D6 strobe, D7 read/write.
// - Unbonded A4, A6 compares still run.
// - Strobe latches port C low address.
// - Bus timing is quarter oscillator rate.
module mdp_port_pins (
	// Clock and reset.
	input wire logic clk,
	input wire logic nrst,
	// Mode strap pins.
	input wire logic mode_a_pin,
	input wire logic mode_b_pin,
	output mdp_pkg::mdp_mode_t mode,
	// Latch and direction writes.
	input wire logic [7:0] wr_data,
	input wire logic pa_wr,
	input wire logic pb_wr,
	input wire logic pc_wr,
	input wire logic pd_wr,
	input wire logic pb_dir_wr,
	input wire logic pc_dir_wr,
	input wire logic pd_dir_wr,
	// Control bits.
	input wire logic pa7_dir,
	input wire logic pa3_dir,
	input wire logic port_c_open_drain_enable,
	// Timer compare outputs for port A bits 7 to 3.
	input wire logic [4:0] oc_enable,
	input wire logic [4:0] oc_level,
	// Port read-back.
	output logic [7:0] pa_rd,
	output logic [7:0] pb_rd,
	output logic [7:0] pc_rd,
	output logic [7:0] pd_rd,
	// External bus requests from the core.
	input wire logic bus_req,
	input wire logic bus_read,
	input wire logic [15:0] bus_addr,
	input wire logic [7:0] bus_wdata,
	output logic bus_done,
	output logic [7:0] bus_rdata,
	output logic e_clk,
	// Serial units.
	input wire logic sci_rx_en,
	input wire logic sci_tx_en,
	input wire logic sci_txd,
	output logic sci_rxd,
	input wire logic spi_en,
	input wire logic [3:0] spi_oe,
	input wire logic [3:0] spi_out,
	output logic [3:0] spi_in,
	// Port A pins.
	input wire logic [7:0] pa_in,
	output logic [7:0] pa_out,
	output logic [7:0] pa_oe,
	// Port B pins.
	input wire logic [7:0] pb_in,
	output logic [7:0] pb_out,
	output logic [7:0] pb_oe,
	// Port C pins.
	input wire logic [7:0] pc_in,
	output logic [7:0] pc_out,
	output logic [7:0] pc_oe,
	// Port D pins.
	input wire logic [7:0] pd_in,
	output logic [7:0] pd_out,
	output logic [7:0] pd_oe
);
	import mdp_pkg::*;

	logic [1:0] phase;
	logic [1:0] mode_s;
	logic [7:0] pa_s;
	logic [7:0] pb_s;
	logic [7:0] pc_s;
	logic [7:0] pd_s;
	logic mode_exp;
	mdp_bus_t bus_state_reg;
	logic [15:0] addr_reg;
	logic [7:0] wdata_reg;
	logic rd_reg;
	logic [1:0] cap_reg;
	logic [7:0] pa_latch;
	logic [7:0] port_b_latch;
	logic [7:0] port_b_direction;
	logic [7:0] port_c_latch;
	logic [7:0] port_c_direction;
	logic [7:0] port_d_latch;
	logic [7:0] port_d_direction;
	logic [7:0] pa_drv;
	logic [7:0] pa_dir;
	logic [7:0] pb_drv;
	logic [7:0] pb_dir;
	logic [7:0] pc_drv;
	logic [7:0] pc_dir;
	logic [7:0] pc_oe_next;
	logic [7:0] pd_drv;
	logic [7:0] pd_dir;
	logic address_latch_strobe;
	logic rw_level;

	mdp_eclk u_eclk (
		.clk(clk),
		.nrst(nrst),
		.phase(phase)
	);

	mdp_sync #(.W(34)) u_sync (
		.clk(clk),
		.d({mode_b_pin, mode_a_pin, pa_in, pb_in, pc_in, pd_in}),
		.q({mode_s, pa_s, pb_s, pc_s, pd_s})
	);

	// Read-back: output bits show the driver input, inputs show the pin.
	function automatic logic [7:0] mdp_readback(input logic [7:0] dir, input logic [7:0] drv,
		input logic [7:0] pin);
		mdp_readback = (dir & drv) | (~dir & pin);
	endfunction

	// The mode is caught while reset is held and frozen at release.
	always_ff @(posedge clk) begin
		if (!nrst) begin
			mode <= mdp_mode_t'(mode_s);
		end
	end

	assign mode_exp = (mode == MDP_EXPANDED) || (mode == MDP_TEST);

	// Latches and direction registers.
	always_ff @(posedge clk) begin
		if (!nrst) begin
			pa_latch <= MDP_LATCH_RST;
			port_b_latch <= MDP_LATCH_RST;
			port_c_latch <= MDP_LATCH_RST;
			port_d_latch <= MDP_LATCH_RST;
		end else begin
			if (pa_wr) begin
				pa_latch <= wr_data;
			end
			if (pb_wr) begin
				port_b_latch <= wr_data;
			end
			if (pc_wr) begin
				port_c_latch <= wr_data;
			end
			if (pd_wr) begin
				port_d_latch <= wr_data;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			port_b_direction <= MDP_DIR_RST;
			port_c_direction <= MDP_DIR_RST;
			port_d_direction <= MDP_DIR_RST;
		end else begin
			if (pb_dir_wr) begin
				port_b_direction <= wr_data;
			end
			if (pc_dir_wr) begin
				port_c_direction <= wr_data;
			end
			if (pd_dir_wr) begin
				port_d_direction <= wr_data;
			end
		end
	end

	// Bus sequencer: a cycle starts only from idle at the period boundary,
	// so a request dropped with its done pulse is taken once; held one cycle past it, it starts a second cycle.
	always_ff @(posedge clk) begin
		if (!nrst) begin
			bus_state_reg <= MDP_BUS_IDLE;
			addr_reg <= MDP_ADDR_RST;
			wdata_reg <= MDP_LATCH_RST;
			rd_reg <= 1'b1;
		end else begin
			case (bus_state_reg)
				MDP_BUS_IDLE: begin
					if (mode_exp && bus_req && phase == MDP_PH_LAST) begin
						bus_state_reg <= MDP_BUS_ADDR;
						addr_reg <= bus_addr;
						wdata_reg <= bus_wdata;
						rd_reg <= bus_read;
					end
				end
				MDP_BUS_ADDR: begin
					if (phase == MDP_PH_DATA - 2'h1) begin
						bus_state_reg <= MDP_BUS_DATA;
					end
				end
				MDP_BUS_DATA: begin
					if (phase == MDP_PH_LAST) begin
						bus_state_reg <= MDP_BUS_IDLE;
					end
				end
				default: begin
					bus_state_reg <= MDP_BUS_IDLE;
				end
			endcase
		end
	end

	// The pin is sampled through the synchroniser, so the read byte is
	// taken two cycles after the E-high phase ends, when the synchronised
	// copy shows the pin as it stood at that end.
	always_ff @(posedge clk) begin
		if (!nrst) begin
			cap_reg <= MDP_CAP_RST;
			bus_done <= 1'b0;
			bus_rdata <= MDP_LATCH_RST;
		end else begin
			cap_reg <= {cap_reg[0], bus_state_reg == MDP_BUS_DATA && phase == MDP_PH_LAST};
			bus_done <= cap_reg[1];
			if (cap_reg[1] && rd_reg) begin
				bus_rdata <= pc_s;
			end
		end
	end

	// Strobe in the first low phase; port C address is held one more
	// phase after it falls so external latches see hold time.
	assign address_latch_strobe = (bus_state_reg == MDP_BUS_ADDR) && (phase == MDP_PH_STROBE);
	// Read/write idles high and drops only for a write cycle.
	assign rw_level = (bus_state_reg == MDP_BUS_IDLE) || rd_reg;

	// Port A: compare outputs take over bits 7 to 3; bits 6 to 4 are fixed
	// outputs, bits 2 to 0 fixed inputs.
	always_comb begin
		pa_drv = pa_latch;
		pa_dir = MDP_PA_FIXED_OUT;
		for (int i = MDP_PA_OC_LO; i <= MDP_PA_OC_HI; i++) begin
			if (oc_enable[i - MDP_PA_OC_LO]) begin
				pa_drv[i] = oc_level[i - MDP_PA_OC_LO];
			end
		end
		pa_dir[MDP_PA_OC_HI] = oc_enable[4] | pa7_dir;
		pa_dir[MDP_PA_OC_LO] = oc_enable[0] | pa3_dir;
	end

	// Port B: address high byte in bus modes, else direction picks output.
	always_comb begin
		if (mode_exp) begin
			pb_drv = addr_reg[15:8];
			pb_dir = 8'hFF;
		end else begin
			pb_drv = port_b_latch;
			pb_dir = port_b_direction;
		end
	end

	// Port C: address then data in bus modes; open drain only single-chip.
	always_comb begin
		pc_drv = port_c_latch;
		pc_dir = port_c_direction;
		pc_oe_next = port_c_direction;
		if (mode_exp) begin
			pc_drv = addr_reg[7:0];
			pc_dir = 8'h00;
			pc_oe_next = 8'h00;
			if (bus_state_reg == MDP_BUS_ADDR) begin
				pc_dir = 8'hFF;
				pc_oe_next = 8'hFF;
			end else if (bus_state_reg == MDP_BUS_DATA && !rd_reg) begin
				pc_drv = wdata_reg;
				pc_dir = 8'hFF;
				pc_oe_next = 8'hFF;
			end
		end else if (mode == MDP_SINGLE && port_c_open_drain_enable) begin
			pc_oe_next = port_c_direction & ~port_c_latch;
		end
	end

	// Port D: serial units borrow bits 0 to 5, bus control takes 6 and 7.
	always_comb begin
		pd_drv = port_d_latch;
		pd_dir = port_d_direction;
		if (sci_rx_en) begin
			pd_dir[MDP_PD_RXD] = 1'b0;
		end
		if (sci_tx_en) begin
			pd_dir[MDP_PD_TXD] = 1'b1;
			pd_drv[MDP_PD_TXD] = sci_txd;
		end
		if (spi_en) begin
			pd_dir[MDP_PD_SPI_HI:MDP_PD_SPI_LO] = spi_oe;
			pd_drv[MDP_PD_SPI_HI:MDP_PD_SPI_LO] = spi_out;
		end
		if (mode_exp) begin
			pd_dir[MDP_PD_RW:MDP_PD_STROBE] = 2'h3;
			pd_drv[MDP_PD_STROBE] = address_latch_strobe;
			pd_drv[MDP_PD_RW] = rw_level;
		end
	end

	// Pin drivers are registered so every pin moves on the same edge.
	always_ff @(posedge clk) begin
		if (!nrst) begin
			pa_out <= MDP_LATCH_RST;
			pa_oe <= MDP_PA_FIXED_OUT;
			pb_out <= MDP_LATCH_RST;
			pb_oe <= MDP_DIR_RST;
			pc_out <= MDP_LATCH_RST;
			pc_oe <= MDP_DIR_RST;
			pd_out <= MDP_LATCH_RST;
			pd_oe <= MDP_DIR_RST;
			e_clk <= 1'b0;
		end else begin
			pa_out <= pa_drv;
			pa_oe <= pa_dir;
			pb_out <= pb_drv;
			pb_oe <= pb_dir;
			pc_out <= pc_drv;
			pc_oe <= pc_oe_next;
			pd_out <= pd_drv;
			pd_oe <= pd_dir;
			e_clk <= phase[1];
		end
	end

	// Bits 4 and 6 keep their compare value internally even where no pin
	// is bonded out, so software can still poll them as timers.
	always_ff @(posedge clk) begin
		if (!nrst) begin
			pa_rd <= MDP_LATCH_RST;
			pb_rd <= MDP_LATCH_RST;
			pc_rd <= MDP_LATCH_RST;
			pd_rd <= MDP_LATCH_RST;
		end else begin
			pa_rd <= mdp_readback(pa_dir, pa_drv, pa_s);
			pb_rd <= mdp_readback(pb_dir, pb_drv, pb_s);
			pc_rd <= mdp_readback(pc_dir, pc_drv, pc_s);
			pd_rd <= mdp_readback(pd_dir, pd_drv, pd_s);
		end
	end

	assign sci_rxd = pd_s[MDP_PD_RXD];
	assign spi_in = pd_s[MDP_PD_SPI_HI:MDP_PD_SPI_LO];

	AST_PB_ADDR: assert property (@(posedge clk) disable iff (!nrst)
		mode_exp && bus_state_reg == MDP_BUS_ADDR |=> pb_oe == 8'hFF && pb_out == addr_reg[15:8])
		else $error("port B does not carry the high address");

	AST_RW_READ: assert property (@(posedge clk) disable iff (!nrst)
		mode_exp && bus_state_reg != MDP_BUS_IDLE && rd_reg |=> pd_out[7] && pd_oe[7])
		else $error("read/write line not high in a read cycle");

	AST_PC_TURN: assert property (@(posedge clk) disable iff (!nrst)
		mode_exp && bus_state_reg == MDP_BUS_DATA && rd_reg |=> pc_oe == 8'h00)
		else $error("port C driven during read data phase");

	AST_OPEN_DRAIN: assert property (@(posedge clk) disable iff (!nrst)
		mode == MDP_SINGLE && port_c_open_drain_enable |=> (pc_oe & pc_out) == 8'h00)
		else $error("port C drives high in open-drain mode");

	AST_PA_RESET: assert property (@(posedge clk) disable iff (!nrst)
		$rose(nrst) |-> pa_oe == 8'h70 && pa_out[6:4] == 3'h0)
		else $error("port A reset direction wrong");

	AST_E_PERIOD: assert property (@(posedge clk) disable iff (!nrst)
		$rose(e_clk) |-> e_clk[*2] ##1 !e_clk[*2] ##1 e_clk)
		else $error("bus timing period not four oscillator cycles");

	AST_STROBE: assert property (@(posedge clk) disable iff (!nrst)
		mode_exp && pd_out[6] |-> pc_oe == 8'hFF ##1 !pd_out[6] && $stable(pc_out) && pc_oe == 8'hFF)
		else $error("low address not stable across the strobe");

	AST_OC_OWNS: assert property (@(posedge clk) disable iff (!nrst)
		oc_enable[4] && pa_wr |=> pa_out[7] == $past(oc_level[4]))
		else $error("port A write disturbed a compare pin");

	AST_PB_GPIO: assert property (@(posedge clk) disable iff (!nrst)
		!mode_exp && port_b_direction == 8'h00 |=> pb_oe == 8'h00)
		else $error("port B driven while configured as input");

	AST_BUS_CTRL: assert property (@(posedge clk) disable iff (!nrst)
		mode_exp |=> pd_oe[7:6] == 2'h3)
		else $error("bus control pins not driven in bus modes");
endmodule

// file: testbench/mdp_ext_mem.sv
`timescale 1ns/100ps
module mdp_ext_mem (
	// Clock and select.
	input wire logic clk,
	input wire logic sel,
	// Bus pins seen from outside.
	input wire logic e_clk,
	input wire logic [7:0] pb_out,
	input wire logic [7:0] pc_out,
	input wire logic [7:0] pc_oe,
	input wire logic [7:0] pd_out,
	input wire logic [7:0] pd_oe,
	// Level put on port C, and what the last strobe captured.
	output logic [7:0] c_ext,
	output logic [15:0] cap_addr,
	output logic cap_rw
);
	logic [7:0] mem [256];
	logic [7:0] last;
	logic drive;
	logic act;
	logic e_seen;
	initial begin
		act = 1'b0;
		e_seen = 1'b0;
		for (int i = 0; i < 256; i++) begin
			mem[i] = 8'(i) ^ 8'h3C;
		end
		last = 8'h00;
		cap_addr = 16'h0000;
		cap_rw = 1'b0;
	end
	// A released bus shows the inverse of the last byte, so a stale value never passes.
	// Only the E-high half of a cycle opened by a strobe drives, so a late or early sample fails.
	assign drive = sel & act & e_clk & pd_oe[7] & pd_out[7];
	assign c_ext = drive ? mem[cap_addr[7:0]] : ~last;
	always @(posedge clk) begin
		if (sel && pd_oe[6] && pd_out[6]) begin
			cap_addr <= {pb_out, pc_out};
			cap_rw <= pd_out[7];
			act <= 1'b1;
			e_seen <= 1'b0;
		end else if (act && e_clk) begin
			e_seen <= 1'b1;
		end else if (e_seen) begin
			act <= 1'b0;
			e_seen <= 1'b0;
		end
		if (drive) begin
			last <= c_ext;
		end
		if (sel && act && e_clk && pd_oe[7] && !pd_out[7]) begin
			mem[cap_addr[7:0]] <= (pc_out & pc_oe) | (~pc_oe & ~last);
		end
	end
endmodule

// file: testbench/mdp_port_pins_tb_top.sv
`timescale 1ns/100ps
module mdp_port_pins_tb_top;
	import mdp_pkg::*;
	logic clk, nrst, mode_a_pin, mode_b_pin, pa7_dir, pa3_dir, od_en, prev;
	mdp_mode_t mode;
	logic [7:0] wr_data, pa_rd, pb_rd, pc_rd, pd_rd, bus_wdata, bus_rdata, v, w, e;
	logic [6:0] wrv;
	logic [4:0] oc_enable, oc_level;
	logic bus_req, bus_read, bus_done, e_clk, cap_rw;
	logic sci_rx_en, sci_tx_en, sci_txd, sci_rxd, spi_en;
	logic [3:0] spi_oe, spi_out, spi_in;
	logic [7:0] pa_out, pa_oe, pb_out, pb_oe, pc_out, pc_oe, pd_out, pd_oe, c_ext;
	logic [7:0] tb_pa, tb_pb, tb_pc, tb_pd, pa_pin, pb_pin, pc_pin, pd_pin;
	logic [15:0] bus_addr, cap_addr, a;
	logic [31:0] lfsr;
	logic [7:0] shadow [256];
	logic [7:0] lat [4];
	logic [7:0] dir [4];
	int fails, compares, n;

	assign pa_pin = (pa_oe & pa_out) | (~pa_oe & tb_pa);
	assign pb_pin = (pb_oe & pb_out) | (~pb_oe & tb_pb);
	assign pc_pin = (pc_oe & pc_out) | (~pc_oe & (mode[0] ? c_ext : tb_pc));
	assign pd_pin = (pd_oe & pd_out) | (~pd_oe & tb_pd);

	mdp_port_pins uut (.clk(clk), .nrst(nrst), .mode_a_pin(mode_a_pin), .mode_b_pin(mode_b_pin),
		.mode(mode), .wr_data(wr_data), .pa_wr(wrv[0]), .pb_wr(wrv[1]), .pc_wr(wrv[2]),
		.pd_wr(wrv[3]), .pb_dir_wr(wrv[4]), .pc_dir_wr(wrv[5]), .pd_dir_wr(wrv[6]),
		.pa7_dir(pa7_dir), .pa3_dir(pa3_dir), .port_c_open_drain_enable(od_en),
		.oc_enable(oc_enable), .oc_level(oc_level), .pa_rd(pa_rd), .pb_rd(pb_rd), .pc_rd(pc_rd),
		.pd_rd(pd_rd), .bus_req(bus_req), .bus_read(bus_read), .bus_addr(bus_addr),
		.bus_wdata(bus_wdata), .bus_done(bus_done), .bus_rdata(bus_rdata), .e_clk(e_clk),
		.sci_rx_en(sci_rx_en), .sci_tx_en(sci_tx_en), .sci_txd(sci_txd), .sci_rxd(sci_rxd),
		.spi_en(spi_en), .spi_oe(spi_oe), .spi_out(spi_out), .spi_in(spi_in),
		.pa_in(pa_pin), .pa_out(pa_out), .pa_oe(pa_oe), .pb_in(pb_pin), .pb_out(pb_out),
		.pb_oe(pb_oe), .pc_in(pc_pin), .pc_out(pc_out), .pc_oe(pc_oe), .pd_in(pd_pin),
		.pd_out(pd_out), .pd_oe(pd_oe));

	mdp_ext_mem mem_model (.clk(clk), .sel(mode[0]), .e_clk(e_clk), .pb_out(pb_out),
		.pc_out(pc_out), .pc_oe(pc_oe), .pd_out(pd_out), .pd_oe(pd_oe), .c_ext(c_ext),
		.cap_addr(cap_addr), .cap_rw(cap_rw));

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	function automatic logic [7:0] rnd();
		repeat (8) lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return lfsr[7:0];
	endfunction

	function automatic logic [7:0] rdx(input logic [7:0] d, input logic [7:0] drv,
		input logic [7:0] pin);
		return (d & drv) | (~d & pin);
	endfunction

	// Compare outputs win over the latch on bits 7 to 3.
	function automatic logic [7:0] pa_drv(input logic [7:0] l, input logic [4:0] ce,
		input logic [4:0] cl);
		logic [7:0] r;
		r = l;
		for (int i = 0; i < 5; i++) begin
			if (ce[i]) begin
				r[i + 3] = cl[i];
			end
		end
		return r;
	endfunction

	function automatic logic [7:0] pa_dir(input logic [7:0] d, input logic [4:0] ce);
		return 8'h70 | {d[7] | ce[4], 3'h0, d[6] | ce[0], 3'h0};
	endfunction

	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask

	task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask

	task automatic complete_run();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic tick(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask

	task automatic rst(input logic [1:0] m);
		@(posedge clk);
		nrst <= 1'b0;
		{mode_b_pin, mode_a_pin} <= m;
		tick(3);
		chk8(pa_oe, MDP_PA_FIXED_OUT);
		chk8(pa_out, 8'h00);
		@(posedge clk);
		nrst <= 1'b1;
		tick(3);
		chk8(pb_oe, m[0] ? 8'hFF : 8'h00);
		chk8({6'h0, mode}, {6'h0, m});
	endtask

	task automatic wr(input int k, input logic [7:0] d);
		@(posedge clk);
		wr_data <= d;
		wrv <= 7'h01 << k;
		@(posedge clk);
		wrv <= 7'h00;
	endtask

	task automatic bus(input logic rd, input logic [15:0] ad, input logic [7:0] d,
		input logic exp_done);
		int k;
		@(posedge clk);
		bus_req <= 1'b1;
		bus_read <= rd;
		bus_addr <= ad;
		bus_wdata <= d;
		k = 0;
		do begin
			tick(1);
			k++;
		end while (bus_done !== 1'b1 && k < 20);
		@(posedge clk);
		bus_req <= 1'b0;
		if (!exp_done) begin
			chk8(8'(k), 8'h14);
		end else if (k >= 20) begin
			fails++;
			complete_run();
		end else begin
			chk16(cap_addr, ad);
			chk8({7'h0, cap_rw}, {7'h0, rd});
			if (rd) begin
				chk8(bus_rdata, shadow[ad[7:0]]);
			end else begin
				shadow[ad[7:0]] = d;
			end
		end
	endtask

	initial begin
		nrst = 1'b0;
		mode_b_pin = 1'b1;
		{mode_a_pin, wr_data, wrv, pa7_dir, pa3_dir, od_en, oc_enable, oc_level} = '0;
		{bus_req, bus_read, bus_addr, bus_wdata, sci_rx_en, sci_tx_en, sci_txd} = '0;
		{spi_en, spi_oe, spi_out, tb_pa, tb_pb, tb_pc, tb_pd, fails, compares} = '0;
		lfsr = 32'h0001109A;
		for (int i = 0; i < 256; i++) begin
			shadow[i] = 8'(i) ^ 8'h3C;
		end
		rst(2'h2);
		repeat (12) begin
			for (int k = 1; k < 4; k++) begin
				lat[k] = rnd();
				dir[k] = rnd();
				wr(k, lat[k]);
				wr(k + 3, dir[k]);
			end
			@(posedge clk);
			tb_pb <= rnd();
			tb_pc <= rnd();
			tb_pd <= rnd();
			tick(4);
			chk8(pb_oe, dir[1]);
			chk8(pb_out & dir[1], lat[1] & dir[1]);
			chk8(pb_rd, rdx(dir[1], lat[1], tb_pb));
			chk8(pc_oe, dir[2]);
			chk8(pc_out & dir[2], lat[2] & dir[2]);
			chk8(pc_rd, rdx(dir[2], lat[2], tb_pc));
			chk8(pd_oe, dir[3]);
			chk8(pd_out & dir[3], lat[3] & dir[3]);
			chk8(pd_rd, rdx(dir[3], lat[3], tb_pd));
		end
		for (int i = 0; i < 10; i++) begin
			lat[0] = rnd();
			v = (i == 0) ? 8'h1F : rnd();
			w = rnd();
			wr(0, lat[0]);
			@(posedge clk);
			oc_enable <= v[4:0];
			oc_level <= w[4:0];
			pa7_dir <= w[7];
			pa3_dir <= w[6];
			tb_pa <= rnd();
			tick(4);
			e = pa_dir(w, v[4:0]);
			chk8(pa_oe, e);
			chk8(pa_out & e, pa_drv(lat[0], v[4:0], w[4:0]) & e);
			chk8(pa_rd, rdx(e, pa_drv(lat[0], v[4:0], w[4:0]), tb_pa));
		end
		// A pull-up stands on port C while it is open drain.
		@(posedge clk);
		od_en <= 1'b1;
		tb_pc <= 8'hFF;
		wr(5, 8'hFF);
		v = rnd();
		wr(2, v);
		tick(4);
		chk8(pc_oe, ~v);
		chk8(pc_out & pc_oe, 8'h00);
		chk8(pc_rd, v);
		@(posedge clk);
		v = rnd();
		sci_rx_en <= 1'b1;
		sci_tx_en <= 1'b1;
		spi_en <= 1'b1;
		sci_txd <= v[0];
		spi_oe <= v[4:1];
		spi_out <= 4'(rnd());
		tb_pd <= rnd();
		tick(4);
		chk8({7'h0, sci_rxd}, {7'h0, pd_pin[0]});
		chk8(pd_oe & 8'h3F, {2'h0, v[4:1], 2'h2});
		chk8(pd_out & 8'h02, {6'h0, v[0], 1'h0});
		chk8({4'h0, spi_in}, {4'h0, pd_pin[5:2]});
		bus(1'b1, 16'h1234, 8'h00, 1'b0);
		n = 0;
		repeat (40) begin
			prev = e_clk;
			tick(1);
			n += (!prev && e_clk) ? 1 : 0;
		end
		chk8(8'(n), 8'h0A);
		@(posedge clk);
		{sci_rx_en, sci_tx_en, spi_en} <= 3'h0;
		rst(2'h3);
		wr(1, 8'hA5);
		repeat (10) begin
			a = {rnd(), rnd()};
			v = rnd();
			bus(1'b0, a, v, 1'b1);
			bus(1'b1, a, v, 1'b1);
			bus(1'b1, a ^ 16'h8001, v, 1'b1);
		end
		rst(2'h1);
		bus(1'b1, 16'hFF00, 8'h00, 1'b1);
		rst(2'h0);
		// Open drain is still requested here, but boot mode must drive port C both ways.
		wr(5, 8'hFF);
		v = rnd();
		wr(2, v);
		tick(4);
		chk8(pc_oe, 8'hFF);
		chk8(pc_out, v);
		bus(1'b0, 16'h0F0F, 8'h00, 1'b0);
		complete_run();
	end
endmodule
